/* File: logic/rwt_pkg.sv */
`default_nettype none
package rwt_pkg;
  localparam int unsigned WIDTH      = 8;
  localparam logic [7:0]  RELOAD_RST = 8'hff;
  localparam logic [7:0]  COUNT_RST  = 8'hff;
  localparam logic        SEL_BOTH   = 1'b0;
  localparam logic        SEL_RELOAD = 1'b1;
  localparam logic        SEL_RST    = 1'b0;
endpackage
`default_nettype wire

/* File: logic/rwt_timer.sv */
// Notes on behaviour
// R1: Prescaler on count tick, timer on underflow
// R2: Each stage has reload and counter
// R3: Running writes steered by write select
// R4: Prescaler counter loads only on tick
// R5: Timer counter loads only on prescaler underflow
// R6: Counter read shows old value until sync
// R7: Reload-only writes land at stage reloads
// R8: Select 0 both, 1 reload only
// R9: Decrement, reload on underflow, keep counting
// R10: Stopped writes load reload and counter
// R11: Software starts with 1, stops with 0
// R12: Pending flag per stage until transfer
`timescale 1ns/1ps
`default_nettype none
module rwt_timer (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       count_tick,
  input  wire logic       count_run_bit,
  input  wire logic       reload_write_select,
  input  wire logic       pre_wr,
  input  wire logic       tmr_wr,
  input  wire logic [7:0] wr_data,
  output logic      [7:0] prescaler_value,
  output logic      [7:0] timer_stage_value,
  output logic      [7:0] prescaler_reload,
  output logic      [7:0] timer_reload,
  output logic            pre_pending,
  output logic            tmr_pending,
  output logic            pre_underflow,
  output logic            tmr_underflow
);
  typedef struct packed {
    logic [7:0] pre_rel;
    logic [7:0] pre_cnt;
    logic [7:0] tmr_rel;
    logic [7:0] tmr_cnt;
    logic       pre_pend;
    logic       tmr_pend;
    logic       pre_uf;
    logic       tmr_uf;
  } rwt_state_t;

  rwt_state_t st;
  rwt_state_t next_st;

  logic run_tick;
  logic pre_zero;
  logic tmr_step;
  logic tmr_zero;

  assign run_tick = count_run_bit && count_tick;            // [R11]
  assign pre_zero = (st.pre_cnt == 8'h00);
  assign tmr_step = run_tick && pre_zero;                   // [R1]
  assign tmr_zero = (st.tmr_cnt == 8'h00);

  // One stage's counter on its sync event: a pending transfer and an
  // underflow both take the reload value, otherwise count down
  function automatic logic [7:0] rwt_sync_count(
    input logic [7:0] cnt,
    input logic [7:0] rel,
    input logic       pend
  );
    if (cnt == 8'h00 || pend) begin
      return rel;
    end
    return cnt - 8'h01;
  endfunction

  // Write-select decode shared by both stages
  function automatic logic rwt_arms_transfer(input logic sel);
    return sel == rwt_pkg::SEL_BOTH;                        // [R8]
  endfunction

  always_comb begin
    next_st = st;
    next_st.pre_uf = 1'b0;
    next_st.tmr_uf = 1'b0;
    // Prescaler stage: pending value enters only on a tick
    if (run_tick) begin                                     // [R4]
      next_st.pre_cnt  = rwt_sync_count(st.pre_cnt, st.pre_rel,
                                        st.pre_pend);       // [R9] [R12]
      next_st.pre_pend = 1'b0;
      next_st.pre_uf   = pre_zero;
    end
    // Timer stage: steps and loads only on prescaler underflow
    if (tmr_step) begin                                     // [R5]
      next_st.tmr_cnt  = rwt_sync_count(st.tmr_cnt, st.tmr_rel,
                                        st.tmr_pend);       // [R9] [R12]
      next_st.tmr_pend = 1'b0;
      next_st.tmr_uf   = tmr_zero;
    end
    // Writes come last so that a write meeting a transfer still pends
    if (pre_wr) begin                                       // [R2]
      next_st.pre_rel = wr_data;
      if (!count_run_bit) begin                             // [R10]
        next_st.pre_cnt  = wr_data;
        next_st.pre_pend = 1'b0;
      end else if (rwt_arms_transfer(reload_write_select)) begin // [R3] [R8]
        next_st.pre_pend = 1'b1;                            // [R6] [R12]
      end
    end
    if (tmr_wr) begin
      next_st.tmr_rel = wr_data;
      if (!count_run_bit) begin                             // [R10]
        next_st.tmr_cnt  = wr_data;
        next_st.tmr_pend = 1'b0;
      end else if (rwt_arms_transfer(reload_write_select)) begin // [R3] [R8]
        next_st.tmr_pend = 1'b1;                            // [R6] [R12]
      end
      // Reload-only writes simply wait for the next underflow [R7]
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st <= '{rwt_pkg::RELOAD_RST, rwt_pkg::COUNT_RST,
              rwt_pkg::RELOAD_RST, rwt_pkg::COUNT_RST,
              1'b0, 1'b0, 1'b0, 1'b0};
    end else begin
      st <= next_st;
    end
  end

  assign prescaler_value   = st.pre_cnt;
  assign timer_stage_value = st.tmr_cnt;
  assign prescaler_reload  = st.pre_rel;
  assign timer_reload      = st.tmr_rel;
  assign pre_pending       = st.pre_pend;
  assign tmr_pending       = st.tmr_pend;
  assign pre_underflow     = st.pre_uf;
  assign tmr_underflow     = st.tmr_uf;

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  pre_hold_a: assert property (                             // [R4]
    !run_tick && !(pre_wr && !count_run_bit) |=> $stable(st.pre_cnt))
    else $error("prescaler counter moved without tick");
  tmr_hold_a: assert property (                             // [R5]
    !tmr_step && !(tmr_wr && !count_run_bit) |=> $stable(st.tmr_cnt))
    else $error("timer counter moved without underflow");
  run_write_a: assert property (                            // [R3]
    pre_wr && count_run_bit && !run_tick |=> st.pre_cnt == $past(st.pre_cnt))
    else $error("running write reached prescaler counter");
  both_pend_a: assert property (                            // [R8]
    tmr_wr && count_run_bit && !reload_write_select |=> st.tmr_pend)
    else $error("write both did not pend");
  rel_only_a: assert property (                             // [R7]
    pre_wr && count_run_bit && reload_write_select && !st.pre_pend
    |=> !st.pre_pend)
    else $error("reload only write pended");
  stop_load_a: assert property (                            // [R10]
    tmr_wr && !count_run_bit |=> st.tmr_cnt == $past(wr_data))
    else $error("stopped write missed counter");
  pend_xfer_a: assert property (                            // [R12]
    st.pre_pend && run_tick && !pre_wr
    |=> !st.pre_pend && st.pre_cnt == $past(st.pre_rel))
    else $error("pending prescaler transfer wrong");
  pre_reload_a: assert property (                           // [R9]
    run_tick && pre_zero && !pre_wr
    |=> st.pre_cnt == $past(st.pre_rel) && st.pre_uf)
    else $error("prescaler reload wrong");
  tmr_dec_a: assert property (                              // [R1]
    tmr_step && !tmr_zero && !st.tmr_pend && !tmr_wr
    |=> st.tmr_cnt == $past(st.tmr_cnt) - 8'h01)
    else $error("timer did not step on underflow");
  old_read_a: assert property (                             // [R6]
    pre_wr && count_run_bit && !run_tick ##1 !run_tick
    |-> $stable(st.pre_cnt))
    else $error("counter changed before sync");

  pre_pend_a: assert property (                             // [R3]
    pre_wr && count_run_bit && reload_write_select == rwt_pkg::SEL_BOTH
    |=> st.pre_pend)
    else $error("prescaler write both did not pend");
  tmr_run_write_a: assert property (                        // [R3]
    tmr_wr && count_run_bit && !tmr_step
    |=> st.tmr_cnt == $past(st.tmr_cnt))
    else $error("running write reached timer counter");
  tmr_rel_only_a: assert property (                         // [R7]
    tmr_wr && count_run_bit && reload_write_select == rwt_pkg::SEL_RELOAD
    && !st.tmr_pend |=> !st.tmr_pend && st.tmr_rel == $past(wr_data))
    else $error("reload only write armed timer transfer");
  tmr_xfer_a: assert property (                             // [R12]
    st.tmr_pend && tmr_step && !tmr_wr
    |=> !st.tmr_pend && st.tmr_cnt == $past(st.tmr_rel))
    else $error("pending timer transfer wrong");
  tmr_reload_a: assert property (                           // [R9]
    tmr_step && tmr_zero && !tmr_wr
    |=> st.tmr_cnt == $past(st.tmr_rel) && st.tmr_uf)
    else $error("timer reload wrong");
  pre_dec_a: assert property (                              // [R9]
    run_tick && !pre_zero && !st.pre_pend && !pre_wr
    |=> st.pre_cnt == $past(st.pre_cnt) - 8'h01 && !st.pre_uf)
    else $error("prescaler did not count down");
  // The timer only ever underflows on a prescaler underflow
  uf_pulse_a: assert property (st.tmr_uf |-> st.pre_uf)     // [R1]
    else $error("timer underflow without prescaler underflow");
  pre_uf_a: assert property (                               // [R9]
    st.pre_uf |-> $past(run_tick) && $past(pre_zero))
    else $error("prescaler underflow without zero tick");
  // A write in the tick cycle must not be swallowed by the transfer
  meet_pend_a: assert property (                            // [R12]
    pre_wr && run_tick && reload_write_select == rwt_pkg::SEL_BOTH
    |=> st.pre_pend && st.pre_rel == $past(wr_data))
    else $error("write meeting a tick lost its transfer");
  stop_pre_a: assert property (                             // [R10]
    pre_wr && !count_run_bit
    |=> st.pre_cnt == $past(wr_data) && !st.pre_pend)
    else $error("stopped write missed prescaler counter");
  pre_rel_hold_a: assert property (!pre_wr |=> $stable(st.pre_rel)) // [R2]
    else $error("prescaler reload changed without write");
  tmr_rel_hold_a: assert property (!tmr_wr |=> $stable(st.tmr_rel)) // [R2]
    else $error("timer reload changed without write");
  pre_pend_src_a: assert property (                         // [R12]
    !st.pre_pend && !pre_wr |=> !st.pre_pend)
    else $error("prescaler pending set without write");
  tmr_pend_src_a: assert property (                         // [R12]
    !st.tmr_pend && !tmr_wr |=> !st.tmr_pend)
    else $error("timer pending set without write");

  tmr_uf_c:   cover property (st.tmr_uf);
  pend_c:     cover property (st.tmr_pend ##[1:50] !st.tmr_pend);
  rel_only_c: cover property (tmr_wr && count_run_bit && reload_write_select);
  meet_c:     cover property (pre_wr && run_tick);
  stop_wr_c:  cover property (pre_wr && !count_run_bit);
endmodule
`default_nettype wire

/* File: dv/rwt_testbench.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, s) begin \
  compares++; \
  if ((s) !== (e)) begin \
    n_errors++; \
    $display("BAD %s exp %h got %h", n, e, s); \
  end \
end
module testbench;
  typedef struct packed {
    logic       r, s, pw, tw, tk;
    logic [7:0] d, pre, tmr;
    logic       pp, tp, pu, tu;
  } rwt_row_t;
  logic       clk = 1'b0, rst = 1'b1, tick = 1'b0, run = 1'b0;
  logic       sel = 1'b0, pw = 1'b0, tw = 1'b0;
  logic [7:0] d = 8'h00;
  logic [7:0] pre, tmr, prel, trel;
  logic       pp, tp, pu, tu;
  int         n_errors = 0, compares = 0, cyc = 0;
  // Inputs run,sel,pre_wr,tmr_wr,tick,data; then expected outputs
  rwt_row_t   rows [16] = '{
    '{0,0,1,0,0,8'h02,8'h02,8'hff,0,0,0,0},
    '{0,1,0,1,0,8'h02,8'h02,8'h02,0,0,0,0},
    '{1,0,0,0,1,8'h00,8'h01,8'h02,0,0,0,0},
    '{1,0,0,0,1,8'h00,8'h00,8'h02,0,0,0,0},
    '{1,0,0,0,1,8'h00,8'h02,8'h01,0,0,1,0},
    '{1,0,1,0,0,8'h00,8'h02,8'h01,1,0,0,0},
    '{1,0,0,0,1,8'h00,8'h00,8'h01,0,0,0,0},
    '{1,0,0,1,0,8'h07,8'h00,8'h01,0,1,0,0},
    '{1,0,0,0,1,8'h00,8'h00,8'h07,0,0,1,0},
    '{1,1,1,0,0,8'h03,8'h00,8'h07,0,0,0,0},
    '{1,1,0,0,1,8'h00,8'h03,8'h06,0,0,1,0},
    '{1,1,0,1,0,8'h09,8'h03,8'h06,0,0,0,0},
    '{1,1,0,0,1,8'h00,8'h02,8'h06,0,0,0,0},
    '{0,0,0,0,1,8'h00,8'h02,8'h06,0,0,0,0},
    '{0,0,1,1,0,8'h00,8'h00,8'h00,0,0,0,0},
    '{1,0,0,0,1,8'h00,8'h00,8'h00,0,0,1,1}};
  always #2.5 clk = ~clk;
  rwt_timer dut_u (
    .clk                 (clk),
    .rst                 (rst),
    .count_tick          (tick),
    .count_run_bit       (run),
    .reload_write_select (sel),
    .pre_wr              (pw),
    .tmr_wr              (tw),
    .wr_data             (d),
    .prescaler_value     (pre),
    .timer_stage_value   (tmr),
    .prescaler_reload    (prel),
    .timer_reload        (trel),
    .pre_pending         (pp),
    .tmr_pending         (tp),
    .pre_underflow       (pu),
    .tmr_underflow       (tu)
  );
  task print_verdict;
    $display("compares %0d n_errors %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // Strobes are one cycle wide, so every step leaves an idle cycle after
  task step(input logic r_, s_, pw_, tw_, tk_, input logic [7:0] d_);
    @(posedge clk);
    run <= r_;
    sel <= s_;
    pw <= pw_;
    tw <= tw_;
    tick <= tk_;
    d <= d_;
    @(posedge clk);
    pw <= 1'b0;
    tw <= 1'b0;
    tick <= 1'b0;
    #1;
  endtask
  // Generous ceiling: the whole run needs well under 100 cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      n_errors++;
      print_verdict;
    end
  end
  initial begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    #1;
    `CHK("reset", 32'hffffffff, {pre, tmr, prel, trel})
    `CHK("reset_flags", 4'h0, {pp, tp, pu, tu})
    $display("test reset done");
    foreach (rows[i]) begin
      step(rows[i].r, rows[i].s, rows[i].pw, rows[i].tw, rows[i].tk,
           rows[i].d);
      `CHK("row", {rows[i][19:0]}, {pre, tmr, pp, tp, pu, tu})
    end
    $display("test table done");
    // Both stages get a write in the cycle of their own sync event
    step(1'b1, 1'b0, 1'b1, 1'b1, 1'b1, 8'h04);
    `CHK("collide", {8'h04, 1'b1}, {prel, pp})
    `CHK("collide_tmr", {8'h04, 1'b1}, {trel, tp})
    step(1'b1, 1'b0, 1'b0, 1'b0, 1'b1, 8'h00);
    `CHK("late_load", {8'h04, 1'b0}, {pre, pp})
    `CHK("late_tmr", {8'h04, 1'b0}, {tmr, tp})
    step(1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 8'h06);
    `CHK("pend_set", {8'h04, 1'b1}, {tmr, tp})
    // Reset in mid-run must drop the armed transfer as well
    @(posedge clk);
    rst <= 1'b1;
    #1;
    `CHK("rerun_rst", 32'hffffffff, {pre, tmr, prel, trel})
    `CHK("rerun_pend", 2'h0, {pp, tp})
    @(posedge clk);
    rst <= 1'b0;
    step(1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 8'h05);
    `CHK("post_rst", {8'h05, 8'h05, 8'hff}, {pre, prel, tmr})
    $display("test collide and reset done");
    print_verdict;
  end
endmodule
`default_nettype wire
